// ### core/exec_timer.sv
// Execution timer: holds busy for the loaded number of clocks, pulses done on the last one.
// Assumes length is at least two and start is only raised while idle.
`timescale 1ns/1ns
module exec_timer
  import muldiv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  exec_timer_if.timer tif
);

  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (tif.start) begin
      cnt_reg <= tif.length;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - TIMER_LAST;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (tif.start) begin
      busy_reg <= 1'b1;
    end else if (cnt_reg == TIMER_LAST) begin
      busy_reg <= 1'b0;
    end
  end

  // Registered one cycle ahead so done lines up with the last busy cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= !tif.start && (cnt_reg == TIMER_PRE_LAST);
    end
  end

  assign tif.busy = busy_reg;
  assign tif.done = done_reg;

endmodule // exec_timer

// ### core/exec_timer_if.sv
// Start/length handshake between the decoder and its execution timer.
// Assumes both ends share core_clk.
`timescale 1ns/1ns
interface exec_timer_if #(parameter int CW = 9);
  logic start;
  logic [CW-1:0] length;
  logic busy;
  logic done;
  modport ctrl (output start, output length, input busy, input done);
  modport timer (input start, input length, output busy, output done);
endinterface // exec_timer_if

// ### core/muldiv_decode.sv
// Decoder for the multiply/divide, ascii adjust, sign-extend, shift and AND/OR/TEST opcodes.
// Assumes the fetch path presents the opcode, the following byte and the shift amount together.
`timescale 1ns/1ns
module muldiv_decode
  import muldiv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] modrm,
  input wire logic [7:0] shift_amount,
  output logic instr_ready,
  output muldiv_pkg::op_class_t op_class,
  output logic wide_op,
  output logic dir_to_reg,
  output logic [1:0] imm_bytes,
  output logic [2:0] shift_operation_select,
  output logic flags_only,
  output logic illegal_op,
  output logic [muldiv_pkg::CW-1:0] cyc_min,
  output logic [muldiv_pkg::CW-1:0] cyc_max,
  output logic busy,
  output logic done
);

  import muldiv_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic is_mem(input logic [7:0] m);
    return m[7:6] != 2'b11;
  endfunction

  function automatic logic [CW-1:0] pick4(input logic mem, input logic w, input logic [CW-1:0] rb,
                                          input logic [CW-1:0] rw, input logic [CW-1:0] mb,
                                          input logic [CW-1:0] mw);
    return mem ? (w ? mw : mb) : (w ? rw : rb);
  endfunction

  logic accept;
  op_class_t cls_next;
  logic [CW-1:0] min_next;
  logic [CW-1:0] max_next;
  logic [1:0] imm_next;
  logic flags_next;
  logic dir_next;
  logic wide_next;
  logic illegal_next;
  logic mem;
  logic w;
  logic [CW-1:0] n_ext;

  assign accept = instr_valid && instr_ready;
  assign mem = is_mem(modrm);
  assign w = opcode[0];
  assign n_ext = {1'b0, shift_amount};

  always_comb begin
    cls_next = cls_none;
    min_next = ILLEGAL_CYC;
    max_next = ILLEGAL_CYC;
    imm_next = 2'h0;
    flags_next = 1'b0;
    dir_next = 1'b0;
    wide_next = w;
    illegal_next = 1'b0;
    casez (opcode)
      8'b1111011?: begin
        unique case (modrm[5:3])
          3'b101: begin
            cls_next = cls_signed_multiply;
            min_next = pick4(mem, w, SMUL_RB_MIN, SMUL_RW_MIN, SMUL_MB_MIN, SMUL_MW_MIN);
            max_next = pick4(mem, w, SMUL_RB_MAX, SMUL_RW_MAX, SMUL_MB_MAX, SMUL_MW_MAX);
          end
          3'b110: begin
            cls_next = cls_unsigned_divide;
            min_next = pick4(mem, w, DIV_RB, DIV_RW, DIV_MB, DIV_MW);
            max_next = min_next;
          end
          3'b111: begin
            cls_next = cls_signed_divide;
            min_next = pick4(mem, w, SDIV_RB_MIN, SDIV_RW_MIN, SDIV_MB_MIN, SDIV_MW_MIN);
            max_next = pick4(mem, w, SDIV_RB_MAX, SDIV_RW_MAX, SDIV_MB_MAX, SDIV_MW_MAX);
          end
          3'b000: begin
            cls_next = cls_test;
            flags_next = 1'b1;
            imm_next = w ? 2'h2 : 2'h1;
            min_next = mem ? TEST_IMM_M : TEST_IMM_R;
            max_next = min_next;
          end
          // Negate, not and unsigned multiply are decoded by a neighbouring block
          default: illegal_next = 1'b1;
        endcase
      end
      8'b011010?1: begin
        cls_next = cls_signed_multiply_imm;
        wide_next = 1'b1;
        imm_next = opcode[1] ? 2'h1 : 2'h2;
        min_next = mem ? SMULI_M_MIN : SMULI_R_MIN;
        max_next = mem ? SMULI_M_MAX : SMULI_R_MAX;
      end
      8'hd4, 8'hd5: begin
        wide_next = 1'b0;
        if (modrm == ASCII_BASE_BYTE) begin
          cls_next = opcode[0] ? cls_ascii_adjust_before_divide : cls_ascii_adjust_after_multiply;
          min_next = opcode[0] ? ADJ_DIV_CYC : ADJ_MUL_CYC;
          max_next = min_next;
        end else begin
          illegal_next = 1'b1;
        end
      end
      8'h98: begin
        cls_next = cls_sign_extend_byte_to_word;
        wide_next = 1'b1;
        min_next = EXT_BW_CYC;
        max_next = EXT_BW_CYC;
      end
      8'h99: begin
        cls_next = cls_sign_extend_word_to_double;
        wide_next = 1'b1;
        min_next = EXT_WD_CYC;
        max_next = EXT_WD_CYC;
      end
      8'b1101000?: begin
        cls_next = cls_shift;
        min_next = mem ? SHIFT1_M : SHIFT1_R;
        max_next = min_next;
      end
      8'b1101001?, 8'b1100000?: begin
        cls_next = cls_shift;
        imm_next = opcode[4] ? 2'h0 : 2'h1;
        min_next = (mem ? SHIFTN_M_BASE : SHIFTN_R_BASE) + n_ext;
        max_next = min_next;
      end
      8'b001000??, 8'b000010??: begin
        cls_next = opcode[5] ? cls_and : cls_or;
        dir_next = opcode[1];
        min_next = mem ? LOGIC_M : LOGIC_R;
        max_next = min_next;
      end
      8'b1000010?: begin
        cls_next = cls_test;
        flags_next = 1'b1;
        min_next = mem ? LOGIC_M : LOGIC_R;
        max_next = min_next;
      end
      8'b1010100?: begin
        cls_next = cls_test;
        flags_next = 1'b1;
        imm_next = w ? 2'h2 : 2'h1;
        min_next = w ? TEST_ACC_W : TEST_ACC_B;
        max_next = min_next;
      end
      default: illegal_next = 1'b1;
    endcase
  end

  // ****************************************
  // Decoded result registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_class <= cls_none;
      wide_op <= 1'b0;
      dir_to_reg <= 1'b0;
      imm_bytes <= 2'h0;
      shift_operation_select <= 3'h0;
      flags_only <= 1'b0;
      illegal_op <= 1'b0;
      cyc_min <= '0;
      cyc_max <= '0;
    end else if (accept) begin
      op_class <= cls_next;
      wide_op <= wide_next;
      dir_to_reg <= dir_next;
      imm_bytes <= imm_next;
      shift_operation_select <= modrm[5:3];
      flags_only <= flags_next;
      illegal_op <= illegal_next;
      cyc_min <= min_next;
      cyc_max <= max_next;
    end
  end

  // ****************************************
  // Execution timing
  // ****************************************
  // Worst case is charged for ranged counts; data-dependent early finish is not modelled
  exec_timer_if #(.CW(CW)) tif ();

  assign tif.start = accept;
  assign tif.length = max_next;

  exec_timer u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .tif(tif)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      instr_ready <= 1'b1;
    end else if (accept) begin
      instr_ready <= 1'b0;
    end else if (tif.done) begin
      instr_ready <= 1'b1;
    end
  end

  assign busy = tif.busy;
  assign done = tif.done;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_smul_rb_time: assert property (accept && opcode == 8'hf6 && modrm[5:3] == 3'b101 && !mem |=>
    op_class == cls_signed_multiply && cyc_min == 9'd25 && cyc_max == 9'd28) else $error("smul reg byte time");
  a_smul_imm_bytes: assert property (accept && opcode[7:2] == 6'b011010 && opcode[0] |=>
    imm_bytes == ($past(opcode[1]) ? 2'h1 : 2'h2) && wide_op) else $error("smul imm bytes");
  a_div_mw_time: assert property (accept && opcode == 8'hf7 && modrm[5:3] == 3'b110 && mem |=>
    cyc_max == 9'd44 ##43 done) else $error("div mem word time");
  a_sdiv_rb_time: assert property (accept && opcode == 8'hf6 && modrm[5:3] == 3'b111 && !mem |=>
    cyc_min == 9'd44 && cyc_max == 9'd52) else $error("sdiv reg byte time");
  a_adjust_mul_done: assert property (accept && opcode == 8'hd4 && modrm == 8'h0a |=>
    !done [*8] ##11 done ##1 instr_ready) else $error("adjust after multiply time");
  a_adjust_div_time: assert property (accept && opcode == 8'hd5 && modrm == 8'h0a |=>
    op_class == cls_ascii_adjust_before_divide && cyc_max == 9'd15) else $error("adjust before divide time");
  a_ext_byte_done: assert property (accept && opcode == 8'h98 |=>
    busy && !done ##1 done ##1 instr_ready && !busy) else $error("byte to word time");
  a_ext_word_done: assert property (accept && opcode == 8'h99 |=> !done [*3] ##1 done) else $error("word to double time");
  a_shift_count: assert property (accept && opcode[7:1] == 7'b1101001 && !mem |=>
    cyc_max == 9'd5 + {1'b0, $past(shift_amount)} && shift_operation_select == $past(modrm[5:3]))
    else $error("shift count time");
  a_logic_dir: assert property (accept && opcode[7:2] == 6'b000010 && mem |=>
    op_class == cls_or && dir_to_reg == $past(opcode[1]) && cyc_max == 9'd10) else $error("or dir");
  a_test_flags: assert property (accept && opcode[7:1] == 7'b1000010 |=> flags_only) else $error("test flags");
  a_test_imm_len: assert property (accept && opcode[7:1] == 7'b1111011 && modrm[5:3] == 3'b000 |=>
    flags_only && imm_bytes == {$past(opcode[0]), !$past(opcode[0])}) else $error("test imm bytes");
  a_test_acc_time: assert property (accept && opcode[7:1] == 7'b1010100 |=>
    cyc_max == ($past(opcode[0]) ? 9'd4 : 9'd3) && wide_op == $past(opcode[0])) else $error("test acc");
  a_no_reaccept: assert property (accept |=> !instr_ready) else $error("accepted while busy");

  c_divide: cover property (accept && op_class != cls_signed_divide ##1 op_class == cls_signed_divide);
  c_shift_imm: cover property (accept && opcode[7:1] == 7'b1100000 ##1 op_class == cls_shift && imm_bytes == 2'h1);
  c_illegal: cover property (accept ##1 illegal_op);
  c_back_to_back: cover property (done ##1 accept);

endmodule // muldiv_decode

// ### core/muldiv_pkg.sv
// Constants, opcode classes and execution cycle counts for the multiply, divide,
// shift and logic decoder. Assumes a single 100 MHz core clock.
//
// Functional notes
// - 1111011w with middle field 101 is signed multiply, 25-28/34-37/31-34/40-43 clocks.
// - 011010s1 is signed multiply by immediate; s=0 adds a byte; 22-25/29-32 clocks.
// - 1111011w with middle field 110 is unsigned divide, 29/38/35/44 clocks.
// - 1111011w with middle field 111 is signed divide, 44-52/53-61/50-58/59-67 clocks.
// - Bytes d4 then 0a are ascii adjust after multiply, 19 clocks.
// - Bytes d5 then 0a are ascii adjust before divide, 15 clocks.
// - Opcode 98 sign-extends byte to word in 2 clocks.
// - Opcode 99 sign-extends word to double word in 4 clocks.
// - Shift forms by one, by count register, by immediate; middle field selects operation.
// - Conjunction and disjunction register forms use d for direction; 3 or 10 clocks.
// - 1000010w is flags-only AND with register/memory, 3 or 10 clocks.
// - 1111011w middle field 000 is flags-only AND with immediate, 4 or 10 clocks.
// - 1010100w is flags-only AND of accumulator with immediate, 3 or 4 clocks.
package muldiv_pkg;

  localparam int CW = 9;

  typedef enum logic [3:0] {
    cls_none = 4'h0,
    cls_signed_multiply = 4'h1,
    cls_signed_multiply_imm = 4'h2,
    cls_unsigned_divide = 4'h3,
    cls_signed_divide = 4'h4,
    cls_ascii_adjust_after_multiply = 4'h5,
    cls_ascii_adjust_before_divide = 4'h6,
    cls_sign_extend_byte_to_word = 4'h7,
    cls_sign_extend_word_to_double = 4'h8,
    cls_shift = 4'h9,
    cls_and = 4'ha,
    cls_or = 4'hb,
    cls_test = 4'hc
  } op_class_t;

  // Second byte of both ascii adjust forms
  localparam logic [7:0] ASCII_BASE_BYTE = 8'h0a;

  localparam logic [CW-1:0] SMUL_RB_MIN = 9'd25;
  localparam logic [CW-1:0] SMUL_RB_MAX = 9'd28;
  localparam logic [CW-1:0] SMUL_RW_MIN = 9'd34;
  localparam logic [CW-1:0] SMUL_RW_MAX = 9'd37;
  localparam logic [CW-1:0] SMUL_MB_MIN = 9'd31;
  localparam logic [CW-1:0] SMUL_MB_MAX = 9'd34;
  localparam logic [CW-1:0] SMUL_MW_MIN = 9'd40;
  localparam logic [CW-1:0] SMUL_MW_MAX = 9'd43;
  localparam logic [CW-1:0] SMULI_R_MIN = 9'd22;
  localparam logic [CW-1:0] SMULI_R_MAX = 9'd25;
  localparam logic [CW-1:0] SMULI_M_MIN = 9'd29;
  localparam logic [CW-1:0] SMULI_M_MAX = 9'd32;
  localparam logic [CW-1:0] DIV_RB = 9'd29;
  localparam logic [CW-1:0] DIV_RW = 9'd38;
  localparam logic [CW-1:0] DIV_MB = 9'd35;
  localparam logic [CW-1:0] DIV_MW = 9'd44;
  localparam logic [CW-1:0] SDIV_RB_MIN = 9'd44;
  localparam logic [CW-1:0] SDIV_RB_MAX = 9'd52;
  localparam logic [CW-1:0] SDIV_RW_MIN = 9'd53;
  localparam logic [CW-1:0] SDIV_RW_MAX = 9'd61;
  localparam logic [CW-1:0] SDIV_MB_MIN = 9'd50;
  localparam logic [CW-1:0] SDIV_MB_MAX = 9'd58;
  localparam logic [CW-1:0] SDIV_MW_MIN = 9'd59;
  localparam logic [CW-1:0] SDIV_MW_MAX = 9'd67;
  localparam logic [CW-1:0] ADJ_MUL_CYC = 9'd19;
  localparam logic [CW-1:0] ADJ_DIV_CYC = 9'd15;
  localparam logic [CW-1:0] EXT_BW_CYC = 9'd2;
  localparam logic [CW-1:0] EXT_WD_CYC = 9'd4;
  localparam logic [CW-1:0] SHIFT1_R = 9'd2;
  localparam logic [CW-1:0] SHIFT1_M = 9'd15;
  localparam logic [CW-1:0] SHIFTN_R_BASE = 9'd5;
  localparam logic [CW-1:0] SHIFTN_M_BASE = 9'd17;
  localparam logic [CW-1:0] LOGIC_R = 9'd3;
  localparam logic [CW-1:0] LOGIC_M = 9'd10;
  localparam logic [CW-1:0] TEST_IMM_R = 9'd4;
  localparam logic [CW-1:0] TEST_IMM_M = 9'd10;
  localparam logic [CW-1:0] TEST_ACC_B = 9'd3;
  localparam logic [CW-1:0] TEST_ACC_W = 9'd4;
  // Time charged to an opcode outside this group before it is released
  localparam logic [CW-1:0] ILLEGAL_CYC = 9'd2;
  localparam logic [CW-1:0] TIMER_LAST = 9'd1;
  localparam logic [CW-1:0] TIMER_PRE_LAST = 9'd2;

endpackage

// ### tb/muldiv_logic_opcode_decode_tb_top.sv
// Self-checking bench for the multiply/divide, shift and logic opcode decoder.
// Assumes muldiv_pkg and muldiv_decode are compiled first; one 100 MHz clock.
`timescale 1ns/1ns
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module muldiv_logic_opcode_decode_tb_top;
  import muldiv_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] modrm = 8'h00;
  logic [7:0] shift_amount = 8'h00;
  logic instr_ready;
  op_class_t op_class;
  logic wide_op;
  logic dir_to_reg;
  logic [1:0] imm_bytes;
  logic [2:0] shift_operation_select;
  logic flags_only;
  logic illegal_op;
  logic [CW-1:0] cyc_min;
  logic [CW-1:0] cyc_max;
  logic busy;
  logic done;
  int fail_count = 0;
  int n_checks = 0;

  muldiv_decode u_dut (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid), .opcode(opcode),
    .modrm(modrm), .shift_amount(shift_amount), .instr_ready(instr_ready), .op_class(op_class),
    .wide_op(wide_op), .dir_to_reg(dir_to_reg), .imm_bytes(imm_bytes),
    .shift_operation_select(shift_operation_select), .flags_only(flags_only), .illegal_op(illegal_op),
    .cyc_min(cyc_min), .cyc_max(cyc_max), .busy(busy), .done(done));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************
  // Shared transfer and verdict tasks
  // ****************************************
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Issues one instruction, checks the decode, then counts busy cycles up to done.
  // Illegal opcodes only get their flag and occupancy checked; the rest is unspecified.
  task automatic exec(input logic [7:0] op, input logic [7:0] mrm, input logic [7:0] n,
                      input op_class_t cls, input logic w, input logic [1:0] imm,
                      input int mn, input int mx);
    int k;
    @(posedge core_clk);
    opcode <= op;
    modrm <= mrm;
    shift_amount <= n;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    k = 1;
    `CHK(instr_ready, 1'b0)
    `CHK(busy, 1'b1)
    `CHK(illegal_op, (cls == cls_none))
    if (cls != cls_none) begin
      `CHK(op_class, cls)
      `CHK(wide_op, w)
      `CHK(imm_bytes, imm)
      `CHK(cyc_min, mn[CW-1:0])
      `CHK(cyc_max, mx[CW-1:0])
    end
    while (done !== 1'b1 && k < 400) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    // Worst-case figure is what the timer charges
    `CHK(k, mx)
    `CHK(busy, 1'b1)
    @(posedge core_clk);
    #1;
    `CHK(instr_ready, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_multiply();
    exec(8'hf6, 8'he8, 8'h00, cls_signed_multiply, 1'b0, 2'h0, 25, 28);
    exec(8'hf7, 8'he8, 8'h00, cls_signed_multiply, 1'b1, 2'h0, 34, 37);
    exec(8'hf6, 8'h28, 8'h00, cls_signed_multiply, 1'b0, 2'h0, 31, 34);
    exec(8'hf7, 8'h68, 8'h00, cls_signed_multiply, 1'b1, 2'h0, 40, 43);
    exec(8'h69, 8'hc1, 8'h00, cls_signed_multiply_imm, 1'b1, 2'h2, 22, 25);
    exec(8'h6b, 8'h06, 8'h00, cls_signed_multiply_imm, 1'b1, 2'h1, 29, 32);
  endtask

  task automatic t_divide();
    exec(8'hf6, 8'hf0, 8'h00, cls_unsigned_divide, 1'b0, 2'h0, 29, 29);
    exec(8'hf7, 8'hf3, 8'h00, cls_unsigned_divide, 1'b1, 2'h0, 38, 38);
    exec(8'hf6, 8'h30, 8'h00, cls_unsigned_divide, 1'b0, 2'h0, 35, 35);
    exec(8'hf7, 8'hb7, 8'h00, cls_unsigned_divide, 1'b1, 2'h0, 44, 44);
    exec(8'hf6, 8'hf8, 8'h00, cls_signed_divide, 1'b0, 2'h0, 44, 52);
    exec(8'hf7, 8'hfa, 8'h00, cls_signed_divide, 1'b1, 2'h0, 53, 61);
    exec(8'hf6, 8'h38, 8'h00, cls_signed_divide, 1'b0, 2'h0, 50, 58);
    exec(8'hf7, 8'h7c, 8'h00, cls_signed_divide, 1'b1, 2'h0, 59, 67);
    // Middle field 011 belongs to another group
    exec(8'hf7, 8'hd8, 8'h00, cls_none, 1'b0, 2'h0, 2, 2);
  endtask

  task automatic t_adjust_extend();
    exec(8'hd4, 8'h0a, 8'h00, cls_ascii_adjust_after_multiply, 1'b0, 2'h0, 19, 19);
    exec(8'hd5, 8'h0a, 8'h00, cls_ascii_adjust_before_divide, 1'b0, 2'h0, 15, 15);
    exec(8'hd4, 8'h0b, 8'h00, cls_none, 1'b0, 2'h0, 2, 2);
    exec(8'h98, 8'h00, 8'h00, cls_sign_extend_byte_to_word, 1'b1, 2'h0, 2, 2);
    exec(8'h99, 8'h00, 8'h00, cls_sign_extend_word_to_double, 1'b1, 2'h0, 4, 4);
  endtask

  task automatic t_shift();
    exec(8'hd0, 8'he8, 8'h09, cls_shift, 1'b0, 2'h0, 2, 2);
    `CHK(shift_operation_select, 3'h5)
    exec(8'hd1, 8'h38, 8'h09, cls_shift, 1'b1, 2'h0, 15, 15);
    `CHK(shift_operation_select, 3'h7)
    exec(8'hd2, 8'hc0, 8'h03, cls_shift, 1'b0, 2'h0, 8, 8);
    `CHK(shift_operation_select, 3'h0)
    exec(8'hd3, 8'h20, 8'h00, cls_shift, 1'b1, 2'h0, 17, 17);
    exec(8'hc0, 8'hd1, 8'hff, cls_shift, 1'b0, 2'h1, 260, 260);
    `CHK(shift_operation_select, 3'h2)
    exec(8'hc1, 8'h18, 8'h01, cls_shift, 1'b1, 2'h1, 18, 18);
  endtask

  task automatic t_logic();
    exec(8'h20, 8'hc1, 8'h00, cls_and, 1'b0, 2'h0, 3, 3);
    `CHK(dir_to_reg, 1'b0)
    exec(8'h23, 8'h07, 8'h00, cls_and, 1'b1, 2'h0, 10, 10);
    `CHK(dir_to_reg, 1'b1)
    `CHK(flags_only, 1'b0)
    exec(8'h0a, 8'hd9, 8'h00, cls_or, 1'b0, 2'h0, 3, 3);
    `CHK(dir_to_reg, 1'b1)
    exec(8'h09, 8'h46, 8'h00, cls_or, 1'b1, 2'h0, 10, 10);
    `CHK(dir_to_reg, 1'b0)
  endtask

  task automatic t_test();
    exec(8'h84, 8'hc2, 8'h00, cls_test, 1'b0, 2'h0, 3, 3);
    `CHK(flags_only, 1'b1)
    exec(8'h85, 8'h04, 8'h00, cls_test, 1'b1, 2'h0, 10, 10);
    exec(8'hf6, 8'hc3, 8'h00, cls_test, 1'b0, 2'h1, 4, 4);
    `CHK(flags_only, 1'b1)
    exec(8'hf7, 8'h05, 8'h00, cls_test, 1'b1, 2'h2, 10, 10);
    exec(8'ha8, 8'h55, 8'h00, cls_test, 1'b0, 2'h1, 3, 3);
    exec(8'ha9, 8'haa, 8'h00, cls_test, 1'b1, 2'h2, 4, 4);
    `CHK(flags_only, 1'b1)
  endtask

  // A request held through a divide is ignored until the decoder is idle again
  task automatic t_refuse_and_reset();
    @(posedge core_clk);
    opcode <= 8'hf7;
    modrm <= 8'hf0;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    opcode <= 8'h98;
    repeat (37) @(posedge core_clk);
    #1;
    `CHK(done, 1'b1)
    `CHK(op_class, cls_unsigned_divide)
    repeat (2) @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    `CHK(op_class, cls_sign_extend_byte_to_word)
    repeat (2) @(posedge core_clk);
    opcode <= 8'hf7;
    modrm <= 8'h3b;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b0;
    #1;
    `CHK(instr_ready, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(op_class, cls_none)
    @(posedge core_clk);
    rstn <= 1'b1;
    exec(8'h99, 8'h00, 8'h00, cls_sign_extend_word_to_double, 1'b1, 2'h0, 4, 4);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_multiply();
    t_divide();
    t_adjust_extend();
    t_shift();
    t_logic();
    t_test();
    t_refuse_and_reset();
    stop_test();
  end

  // Whole run is under two thousand cycles; ten times that means a hang
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule // muldiv_logic_opcode_decode_tb_top
